// [rtl/ftsp_data_port.sv]
// Data port of a flow-through burst memory with its array and write buffer.
`default_nettype none
`include "ftsp_consts.svh"

module ftsp_data_port import ftsp_pkg::*; #(
    parameter int ADDR_BITS = `FTSP_ADDR_BITS,
    parameter int LANES     = `FTSP_LANES
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic [ADDR_BITS-1:0]          addr_in,
    input  wire logic                          clock_qualify_n,
    input  wire logic                          write_enable_n,
    input  wire logic                          advance_or_load,
    input  wire logic                          chip_select_first_n,
    input  wire logic                          chip_select_second,
    input  wire logic                          chip_select_third_n,
    input  wire logic [LANES-1:0]              byte_lane_select_n,
    input  wire logic                          output_drive_n,
    input  wire logic                          burst_order_strap,
    input  wire logic [LANES*`FTSP_LANE_BITS-1:0] dq_in,
    input  wire logic [LANES-1:0]              parity_lines_in,
    output logic [LANES*`FTSP_LANE_BITS-1:0]   dq_out,
    output logic                               dq_oe,
    output logic [LANES-1:0]                   parity_lines_out,
    output logic                               parity_lines_oe,
    output logic                               commit_ready
);

    // Lane width in the array: one data byte plus its parity bit
    localparam int LB = `FTSP_LANE_BITS;
    localparam int LW = LB + 1;
    localparam int WB = LANES * LW;
    localparam int BB = `FTSP_BURST_BITS;

    // Storage array, no reset: contents are undefined at power-up
    logic [WB-1:0]        mem [2**ADDR_BITS];

    // Cycle state, updated only on qualified edges
    ftsp_op_t             op_q;        // Operation of the current cycle
    logic [ADDR_BITS-1:0] addr_q;      // Address of the current cycle
    logic [ADDR_BITS-1:0] base_q;      // Address loaded at burst start
    logic [BB-1:0]        start_q;     // Low bits at burst start
    logic [BB-1:0]        cnt_q;       // Burst beat counter
    logic [LANES-1:0]     mask_q;      // Lanes selected with the command
    logic                 first_q;     // First cycle out of deselect
    logic [WB-1:0]        rd_word_q;   // Word presented on the pins

    // Strap capture after reset release
    logic                 strap_seen_q;
    logic                 interleave_q;

    // Pin drive enable, follows output drive every edge
    logic                 drive_q;

    // Two-entry write buffer between capture and array
    logic [ADDR_BITS-1:0] buf_addr [2];
    logic [LANES-1:0]     buf_mask [2];
    logic [WB-1:0]        buf_data [2];
    logic                 buf_wr_ptr_q;
    logic                 buf_rd_ptr_q;
    logic [1:0]           buf_count_q;
    logic                 commit_ready_q;

    // Clock qualification: every state change below needs it, except the strap capture and the drive enable
    wire logic qual;
    assign qual = ~clock_qualify_n;

    // Chip selection from the three selects
    wire logic sel_now;
    assign sel_now = ~chip_select_first_n & chip_select_second
                     & ~chip_select_third_n;

    // Operation requested by a load cycle
    ftsp_op_t op_load;
    assign op_load = !sel_now ? FTSP_OP_IDLE :
                     (write_enable_n ? FTSP_OP_READ
                                     : FTSP_OP_WRITE);

    // Advance only continues a running access; when idle it stays idle
    wire logic advancing;
    assign advancing = advance_or_load & (op_q != FTSP_OP_IDLE);

    ftsp_op_t op_cmd;
    assign op_cmd = advance_or_load ? op_q : op_load;

    // Burst address generation
    wire logic [BB-1:0] cnt_next;
    wire logic [BB-1:0] low_lin;
    wire logic [BB-1:0] low_int;
    wire logic [BB-1:0] low_next;
    assign cnt_next = cnt_q + 2'h1;
    assign low_lin  = start_q + cnt_next;
    assign low_int  = start_q ^ cnt_next;
    // Strap high picks the interleaved sequence, low picks linear
    assign low_next = interleave_q ? low_int : low_lin;

    wire logic [ADDR_BITS-1:0] addr_cmd;
    assign addr_cmd = advancing ? {base_q[ADDR_BITS-1:BB], low_next}
                                : addr_in;

    // First cycle after a deselected cycle
    wire logic first_cmd;
    assign first_cmd = (op_q == FTSP_OP_IDLE)
                       & (op_cmd != FTSP_OP_IDLE);

    // Values for the coming cycle; a masked edge keeps everything
    ftsp_op_t op_d;
    wire logic first_d;
    assign op_d    = qual ? op_cmd : op_q;
    assign first_d = qual ? first_cmd : first_q;

    // Pins driven only for a read that is not the first after deselect
    // and while output drive is asserted; writes and idle float the bus
    wire logic drive_d;
    assign drive_d = (op_d == FTSP_OP_READ) & ~first_d
                     & ~output_drive_n;

    // Write data belongs to the command of the previous qualified edge
    wire logic wr_take;
    assign wr_take = qual & (op_q == FTSP_OP_WRITE);

    // Incoming word, parity bit sits above its byte
    logic [WB-1:0] in_word;
    for (genvar g = 0; g < LANES; g++) begin : g_in
        assign in_word[g*LW +: LW] = {parity_lines_in[g],
                                      dq_in[g*LB +: LB]};
    end

    // Lane merge: selected lanes of a newer word replace older ones
    function automatic logic [WB-1:0] merge(
        input logic [WB-1:0]    old_w,
        input logic [WB-1:0]    new_w,
        input logic [LANES-1:0] mask,
        input logic             hit
    );
        logic [WB-1:0] res;
        res = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (hit && mask[i]) begin
                res[i*LW +: LW] = new_w[i*LW +: LW];
            end
        end
        return res;
    endfunction : merge

    // Buffer status
    wire logic buf_full;
    wire logic buf_empty;
    wire logic older_valid;
    wire logic newer_valid;
    assign buf_full    = (buf_count_q == `FTSP_BUF_FULL);
    assign buf_empty   = (buf_count_q == 2'h0);
    assign older_valid = ~buf_empty;
    assign newer_valid = buf_full;

    // A word is lost only if the buffer is already full; commit_ready
    // warns the controller side ahead of that
    wire logic push;
    wire logic pop;
    wire logic drain_ready;
    assign push = wr_take & ~buf_full;
    // Array port is shared: a read cycle stalls the drain
    assign drain_ready = qual & (op_cmd != FTSP_OP_READ);
    assign pop  = ~buf_empty & drain_ready;

    wire logic [1:0] buf_count_d;
    assign buf_count_d = buf_count_q + {1'b0, push} - {1'b0, pop};

    // Read path with forwarding of writes not yet in the array
    wire logic           older_hit;
    wire logic           newer_hit;
    wire logic           in_hit;
    wire logic [WB-1:0]  rd_arr;
    wire logic [WB-1:0]  rd_m1;
    wire logic [WB-1:0]  rd_m2;
    wire logic [WB-1:0]  rd_word_d;
    assign older_hit = older_valid & (buf_addr[buf_rd_ptr_q] == addr_cmd);
    assign newer_hit = newer_valid
                       & (buf_addr[~buf_rd_ptr_q] == addr_cmd);
    assign in_hit    = wr_take & (addr_q == addr_cmd);
    assign rd_arr    = mem[addr_cmd];
    assign rd_m1     = merge(rd_arr, buf_data[buf_rd_ptr_q],
                             buf_mask[buf_rd_ptr_q], older_hit);
    assign rd_m2     = merge(rd_m1, buf_data[~buf_rd_ptr_q],
                             buf_mask[~buf_rd_ptr_q], newer_hit);
    assign rd_word_d = merge(rd_m2, in_word, mask_q, in_hit);

    // Cycle state; held across masked edges
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_q    <= FTSP_OP_IDLE;
            addr_q  <= '0;
            base_q  <= '0;
            start_q <= `FTSP_CNT_RST;
            cnt_q   <= `FTSP_CNT_RST;
            mask_q  <= '0;
            first_q <= 1'b0;
        end else if (qual) begin
            op_q    <= op_cmd;
            addr_q  <= addr_cmd;
            first_q <= first_cmd;
            mask_q  <= ~byte_lane_select_n;
            // Load restarts the counter, advance steps it
            if (advancing) begin
                cnt_q <= cnt_next;
            end else begin
                base_q  <= addr_in;
                start_q <= addr_in[BB-1:0];
                cnt_q   <= `FTSP_CNT_RST;
            end
        end
    end

    // Flow-through word: read with the address sampled at this edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_word_q <= '0;
        end else if (qual && op_cmd == FTSP_OP_READ) begin
            rd_word_q <= rd_word_d;
        end
    end

    // Strap is caught at the first edge after reset release
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_seen_q <= 1'b0;
            interleave_q <= `FTSP_STRAP_RST;
        end else if (!strap_seen_q) begin
            strap_seen_q <= 1'b1;
            interleave_q <= burst_order_strap;
        end
    end

    // Drive enable tracks output drive even on masked edges
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= drive_d;
        end
    end

    // Buffer pointers, count and ready flag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            buf_wr_ptr_q   <= 1'b0;
            buf_rd_ptr_q   <= 1'b0;
            buf_count_q    <= 2'h0;
            commit_ready_q <= `FTSP_READY_RST;
        end else begin
            buf_count_q    <= buf_count_d;
            commit_ready_q <= (buf_count_d != `FTSP_BUF_FULL);
            if (push) begin
                buf_wr_ptr_q <= ~buf_wr_ptr_q;
            end
            if (pop) begin
                buf_rd_ptr_q <= ~buf_rd_ptr_q;
            end
        end
    end

    // Buffer entries: captured data with its address and lanes
    always_ff @(posedge ref_clk) begin
        if (push) begin
            buf_addr[buf_wr_ptr_q] <= addr_q;
            buf_mask[buf_wr_ptr_q] <= mask_q;
            buf_data[buf_wr_ptr_q] <= in_word;
        end
    end

    // Array commit of the oldest entry, selected lanes only
    always_ff @(posedge ref_clk) begin
        if (pop) begin
            for (int i = 0; i < LANES; i++) begin
                if (buf_mask[buf_rd_ptr_q][i]) begin
                    mem[buf_addr[buf_rd_ptr_q]][i*LW +: LW]
                        <= buf_data[buf_rd_ptr_q][i*LW +: LW];
                end
            end
        end
    end

    // Pin outputs split from the registered word
    for (genvar g = 0; g < LANES; g++) begin : g_out
        assign dq_out[g*LB +: LB]  = rd_word_q[g*LW +: LB];
        assign parity_lines_out[g] = rd_word_q[g*LW + LB];
    end

    // Parity lanes share the data enable
    assign dq_oe           = drive_q;
    assign parity_lines_oe = drive_q;
    assign commit_ready    = commit_ready_q;

endmodule : ftsp_data_port
`default_nettype wire

// [rtl/ftsp_consts.svh]
// Constants for the flow-through memory data port.
`ifndef FTSP_CONSTS_SVH
`define FTSP_CONSTS_SVH

// Geometry of the data path
`define FTSP_ADDR_BITS 19
`define FTSP_LANES 4
`define FTSP_LANE_BITS 8
`define FTSP_BURST_BITS 2

// Reset values of control state
`define FTSP_STRAP_RST 1'h1
`define FTSP_CNT_RST 2'h0
`define FTSP_READY_RST 1'h1

// Write buffer depth in entries
`define FTSP_BUF_FULL 2'h2

`endif

// [rtl/ftsp_pkg.sv]
// Types shared by the flow-through memory data port.
`default_nettype none
package ftsp_pkg;

    // Operation held for the current cycle
    typedef enum logic [1:0] {
        FTSP_OP_IDLE  = 2'b00,
        FTSP_OP_READ  = 2'b01,
        FTSP_OP_WRITE = 2'b10
    } ftsp_op_t;

endpackage : ftsp_pkg
`default_nettype wire

// [dv/ftsp_port_asserts.sv]
// Pin-level checks for the flow-through memory data port.
`default_nettype none
`include "ftsp_consts.svh"
module ftsp_port_chk #(
    parameter int LANES = `FTSP_LANES
) (
    input wire logic                             ref_clk,
    input wire logic                             rst,
    input wire logic                             clock_qualify_n,
    input wire logic                             write_enable_n,
    input wire logic                             advance_or_load,
    input wire logic                             chip_select_first_n,
    input wire logic                             chip_select_second,
    input wire logic                             chip_select_third_n,
    input wire logic                             output_drive_n,
    input wire logic [LANES*`FTSP_LANE_BITS-1:0] dq_out,
    input wire logic                             dq_oe,
    input wire logic                             parity_lines_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic sel; // All three selects agree at this edge
    wire logic ld;  // Qualified edge that loads a command
    wire logic rd;  // Selected read load
    assign sel = !chip_select_first_n && chip_select_second
        && !chip_select_third_n;
    assign ld = !clock_qualify_n && !advance_or_load;
    assign rd = ld && sel && write_enable_n;
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    chk_lane_dir_pair:
        assert property (dq_oe == parity_lines_oe)
        else $error("parity enable differs from data enable");
    chk_drive_off_float:
        assert property (output_drive_n |=> !dq_oe)
        else $error("pins driven while drive enable high");
    chk_write_float:
        assert property (ld && sel && !write_enable_n |=> !dq_oe)
        else $error("pins driven in write data phase");
    chk_write_stall_float:
        assert property ((ld && sel && !write_enable_n) ##1 clock_qualify_n
            |=> !dq_oe)
        else $error("pins driven in stalled write data phase");
    chk_deselect_float:
        assert property (ld && !sel |=> !dq_oe)
        else $error("pins driven while deselected");
    chk_first_read_float:
        assert property ((ld && !sel) ##1 rd |=> !dq_oe)
        else $error("pins driven in first cycle after deselect");
    chk_read_drives:
        assert property ((rd && !output_drive_n) ##1 (rd && !output_drive_n)
            |=> dq_oe)
        else $error("read data not driven");
    chk_out_held:
        assert property (!$stable(dq_out) |-> !$past(clock_qualify_n))
        else $error("read word moved on a masked edge");
endmodule : ftsp_port_chk

bind ftsp_data_port ftsp_port_chk #(.LANES(LANES)) u_chk (
    .ref_clk, .rst, .clock_qualify_n, .write_enable_n, .advance_or_load,
    .chip_select_first_n, .chip_select_second, .chip_select_third_n,
    .output_drive_n, .dq_out, .dq_oe, .parity_lines_oe
);
`default_nettype wire

// [dv/ftsp_ctrl_model.sv]
// Controller side of the shared data and parity pins.
`default_nettype none
module ftsp_ctrl_model (
    input  wire logic        ref_clk,
    input  wire logic        ctl_drive,
    input  wire logic [35:0] ctl_data,
    input  wire logic [31:0] dq_out,
    input  wire logic [3:0]  parity_lines_out,
    input  wire logic        dq_oe,
    output logic      [31:0] dq_in,
    output logic      [3:0]  parity_lines_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] last_q = 36'h0; // Pin level at the last edge
    logic [35:0] bus;            // Resolved pin level
    // Two drivers fight to unknown; released pins drift every cycle
    assign bus = (ctl_drive && dq_oe) ? 'x
        : ctl_drive ? ctl_data
        : dq_oe ? {parity_lines_out, dq_out} : ~last_q;
    assign {parity_lines_in, dq_in} = bus;
    // Remember the level so a floating bus never repeats it; a plain
    // always keeps the start value above from counting as a second driver
    always @(posedge ref_clk) begin
        last_q <= bus;
    end
endmodule : ftsp_ctrl_model
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the flow-through memory data port.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst;        // Bench clock, async reset
    logic [5:0]  addr_in;             // Small array keeps runs short
    logic        clock_qualify_n, write_enable_n, advance_or_load;
    logic        chip_select_first_n, chip_select_second;
    logic        chip_select_third_n, output_drive_n, burst_order_strap;
    logic [3:0]  byte_lane_select_n;
    logic        ctl_drive;           // Controller owns the pins
    logic [35:0] ctl_data;            // Parity and data it puts out
    logic        wr_pend;             // Last load was a write
    wire logic [31:0] dq_in, dq_out;
    wire logic [3:0]  parity_lines_in, parity_lines_out;
    wire logic        dq_oe, parity_lines_oe, commit_ready;
    int n_errors;
    int num_checks;

    ftsp_data_port #(.ADDR_BITS(6)) i_dut (
        .ref_clk, .rst, .addr_in, .clock_qualify_n, .write_enable_n,
        .advance_or_load, .chip_select_first_n, .chip_select_second,
        .chip_select_third_n, .byte_lane_select_n, .output_drive_n,
        .burst_order_strap, .dq_in, .parity_lines_in, .dq_out, .dq_oe,
        .parity_lines_out, .parity_lines_oe, .commit_ready
    );
    ftsp_ctrl_model i_ctl (
        .ref_clk, .ctl_drive, .ctl_data, .dq_out, .parity_lines_out,
        .dq_oe, .dq_in, .parity_lines_in
    );

    // 20 ns period
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Counts and verdict, the single exit of the run
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    // One bus cycle; d is the write word of the previous load
    task automatic cyc(input logic q_n, input logic a, input logic w_n,
        input logic s, input logic [5:0] ad, input logic [3:0] ln,
        input logic o_n, input logic [35:0] d);
        @(posedge ref_clk);
        {clock_qualify_n, advance_or_load, write_enable_n,
            chip_select_first_n, addr_in, byte_lane_select_n,
            output_drive_n} <= {q_n, a, w_n, !s, ad, ln, o_n};
        ctl_drive <= wr_pend;
        ctl_data <= d;
        // Only loads change who owns the next data phase
        if (!q_n && !a) begin
            wr_pend = s && !w_n;
        end
    endtask : cyc

    task automatic do_reset(input logic s);
        @(posedge ref_clk);
        burst_order_strap <= s;
        rst <= 1'b1;
        wr_pend = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
    endtask : do_reset

    // Back-to-back writes fill the buffer, then a lane-masked rewrite
    task automatic s_write_lanes;
        int k;
        cyc(0, 0, 0, 1, 6'h08, 4'h0, 0, 36'h0);
        cyc(0, 0, 0, 1, 6'h09, 4'h0, 0, 36'h1_1111_1111);
        #1 chk_flag(dq_oe, 1'b0);
        cyc(0, 0, 1, 1, 6'h14, 4'h0, 0, 36'h2_2222_2222);
        cyc(0, 0, 1, 1, 6'h14, 4'h0, 0, 36'h0);
        #1 chk_flag(commit_ready, 1'b0);
        k = 0;
        while (commit_ready !== 1'b1 && k < 8) begin
            cyc(0, 0, 1, 0, 6'h00, 4'h0, 0, 36'h0);
            #1 k++;
        end
        if (commit_ready !== 1'b1) begin
            n_errors++;
            $display("MISMATCH %0t commit ready never returned", $time);
            wrap_up();
        end
        cyc(0, 0, 0, 1, 6'h09, 4'hA, 0, 36'h0);
        cyc(1, 0, 1, 0, 6'h00, 4'h0, 0, 36'hC_CCCC_CCCC);
        cyc(0, 0, 1, 0, 6'h00, 4'h0, 0, 36'hC_CCCC_CCCC);
        cyc(0, 0, 1, 0, 6'h00, 4'h0, 0, 36'h0);
        cyc(0, 0, 1, 1, 6'h08, 4'h0, 0, 36'h0);
        cyc(0, 0, 1, 1, 6'h09, 4'h0, 0, 36'h0);
        #1 chk_word({parity_lines_out, dq_out}, 36'h1_1111_1111);
        chk_flag(dq_oe, 1'b0);
        cyc(0, 0, 1, 0, 6'h00, 4'h0, 0, 36'h0);
        #1 chk_word({parity_lines_out, dq_out}, 36'h6_22CC_22CC);
        chk_flag(dq_oe, 1'b1);
        cyc(0, 0, 1, 0, 6'h00, 4'h0, 0, 36'h0);
        #1 chk_flag(dq_oe, 1'b0);
    endtask : s_write_lanes

    // chip_select_second alone, then chip_select_third_n alone, must deselect: word kept, pins floated checked after the first
    task automatic s_select;
        cyc(0, 0, 1, 1, 6'h08, 4'h0, 0, 36'h0);
        cyc(0, 0, 1, 1, 6'h08, 4'h0, 0, 36'h0);
        cyc(0, 0, 1, 1, 6'h09, 4'h0, 0, 36'h0);
        chip_select_second <= 1'b0;
        #1 chk_word({parity_lines_out, dq_out}, 36'h1_1111_1111);
        chk_flag(parity_lines_oe, 1'b1);
        cyc(0, 0, 1, 1, 6'h09, 4'h0, 0, 36'h0);
        chip_select_second  <= 1'b1;
        chip_select_third_n <= 1'b1;
        #1 chk_word({parity_lines_out, dq_out}, 36'h1_1111_1111);
        chk_flag(parity_lines_oe, 1'b0);
        cyc(0, 0, 1, 0, 6'h09, 4'h0, 0, 36'h0);
        chip_select_third_n <= 1'b0;
        #1 chk_word({parity_lines_out, dq_out}, 36'h1_1111_1111);
    endtask : s_select

    // Fill one block, then burst-read from word 1 with a stall at the end
    task automatic s_burst(input logic s);
        int k;
        do_reset(s);
        for (int i = 0; i < 4; i++) begin
            cyc(0, 0, 0, 1, 6'h10 + 6'(i), 4'h0, 0,
                36'h5_0000_0A00 + i - 1);
        end
        cyc(0, 0, 1, 0, 6'h00, 4'h0, 0, 36'h5_0000_0A03);
        for (int n = 0; n < 6; n++) begin
            cyc(n > 3, n != 0, 1, 1, 6'h11, 4'h0, n == 2, 36'h0);
            #1 k = (n > 4) ? 3 : n - 1;
            k = s ? (1 ^ k) : ((1 + k) % 4);
            if (n > 0) begin
                chk_word({parity_lines_out, dq_out}, 36'h5_0000_0A00 + k);
                if (n < 5) chk_flag(dq_oe, n == 2 || n == 4);
            end
        end
    endtask : s_burst

    initial begin
        {clock_qualify_n, advance_or_load, write_enable_n} = 3'h7;
        {chip_select_first_n, chip_select_second} = 2'h3;
        {chip_select_third_n, output_drive_n} = 2'h1;
        {addr_in, byte_lane_select_n} = 10'h00F;
        {burst_order_strap, rst, ctl_drive} = 3'h6;
        ctl_data = 36'h0;
        n_errors = 0;
        num_checks = 0;
        do_reset(1'b1);
        s_write_lanes();
        s_select();
        s_burst(1'b0);
        s_burst(1'b1);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
